// ---- design/sbst_pkg.sv ----
// Package for the boundary-scan test access port: constants and types.
package sbst_pkg;

    // Register lengths.
    localparam int IR_LEN    = 3;
    localparam int ID_LEN    = 32;
    localparam int BSR_LEN   = 107;

    // Instruction codes, most significant bit first.
    localparam logic [2:0] INS_EXTEST  = 3'h0;
    localparam logic [2:0] INS_IDCODE  = 3'h1;
    localparam logic [2:0] INS_HIGHZ   = 3'h2;
    localparam logic [2:0] INS_SAMPLE  = 3'h4;
    localparam logic [2:0] INS_BYPASS  = 3'h7;

    // Value after reset of the instruction register.
    localparam logic [2:0] IR_RESET    = INS_IDCODE;

    // Capture pattern for the instruction register: low bits 01.
    localparam logic [2:0] IR_CAPTURE  = 3'h1;

    // Identification field positions.
    localparam int ID_REV_LSB  = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_VEND_LSB = 1;

    // Synchroniser depth for level crossings into the system clock.
    localparam int SYNC_STAGES = 2;

    // The sixteen controller states.
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
        ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } sbst_state_t;

    // Serial test pins seen by the device.
    typedef struct packed {
        logic tms;
        logic tdi;
        logic tms_driven;
        logic tdi_driven;
    } sbst_pins_t;

    // Pin control presented to the RAM input/output ring.
    typedef struct packed {
        logic extest;
        logic highz;
    } sbst_mode_t;

endpackage : sbst_pkg

// ---- design/sbst_tap.sv ----
// Boundary-scan test access port with instruction decode and scan registers.
// Behaviour
// RULE_01: Three-bit instruction decode; other codes reserved.
// RULE_02: IDCODE captures fixed ID, shifts it out.
// RULE_03: IDCODE selected at reset and test-logic-reset.
// RULE_04: BYPASS puts one-bit register in path.
// RULE_05: SAMPLE/PRELOAD captures pins in capture-DR.
// RULE_06: SAMPLE/PRELOAD shifts boundary register in shift-DR.
// RULE_07: Controller holds RAM inputs stable during capture.
// RULE_08: EXTEST drives outputs, captures inputs.
// RULE_09: EXTEST at update-IR enables drivers with preload.
// RULE_10: Controller preloads first vector before EXTEST.
// RULE_11: Sample-highz floats read data, shifts boundary.
// RULE_12: Sample-highz still captures pad values.
// RULE_13: Undriven test data and mode read one.
// RULE_14: Idle port: test clock low, output open.
// RULE_15: Lengths 3, 1, 32 and 107 bits.
// RULE_16: ID fields revision, part, vendor, fixed one.
// RULE_17: Standard sixteen-state controller, output on falling.
`timescale 1ns/1ps

module sbst_tap #(
    parameter int          BSR_W   = sbst_pkg::BSR_LEN,
    parameter logic [3:0]  ID_REV  = 4'h0,   // Arbitrary value.
    parameter logic [15:0] ID_PART = 16'h0001, // Arbitrary value.
    parameter logic [10:0] ID_VEND = 11'h001  // Arbitrary value.
) (
    // System clock and reset.
    input  wire logic              mclk,
    input  wire logic              reset,
    // Test clock domain pins.
    input  wire logic              tck,
    input  wire logic              tms_in,
    input  wire logic              tms_drv,
    input  wire logic              tdi_in,
    input  wire logic              tdi_drv,
    output logic                   tdo_out,
    output logic                   tdo_oe,
    // Pin ring: sampled pad values and the drive vector.
    input  wire logic [BSR_W-1:0]  pad_in,
    output logic [BSR_W-1:0]       pad_drive,
    // Output control, synchronised to mclk.
    output logic                   extest_drv_en,
    output logic                   read_data_highz
);

    // Identification value assembled from its fields.
    localparam logic [31:0] ID_VALUE = {ID_REV, ID_PART, ID_VEND, 1'b1}; // RULE_16

    // Pin view with undriven inputs reading as one.
    sbst_pkg::sbst_pins_t pins;
    logic                 tms;
    logic                 tdi;

    // Controller state and scan registers, all on tck.
    sbst_pkg::sbst_state_t       st_q, st_d;
    logic [2:0]                  ir_sh_q, ir_sh_d;
    logic [2:0]                  ir_q, ir_d;
    logic                        byp_q, byp_d;
    logic [31:0]                 id_q, id_d;
    logic [BSR_W-1:0]            bsr_q, bsr_d;
    logic [BSR_W-1:0]            upd_q, upd_d;
    logic                        tdo_d;     // Next serial output bit.
    logic                        tdo_oe_d;  // Next serial output enable.
    sbst_pkg::sbst_mode_t        mode_tck_q, mode_tck_d;
    logic                        rst_tck_q1, rst_tck_q2;

    // Synchroniser stages for the mode bits into mclk.
    sbst_pkg::sbst_mode_t        mode_s1_q, mode_s2_q;

    // Pad values pass two test clock stages before capture, because the
    // RAM pins move on their own clocks; a held value is only delayed.
    logic [BSR_W-1:0]            pad_s1_q, pad_s2_q;

    // Next values of the registered pin ring controls.
    logic                        drv_en_d;
    logic                        highz_d;

    // Decode helpers.
    // Reserved codes match neither helper and take the one-bit path.
    function automatic logic is_bsr(input logic [2:0] ins);
        is_bsr = (ins == sbst_pkg::INS_EXTEST) ||
                 (ins == sbst_pkg::INS_SAMPLE) ||
                 (ins == sbst_pkg::INS_HIGHZ); // RULE_01
    endfunction

    function automatic logic is_id(input logic [2:0] ins);
        is_id = (ins == sbst_pkg::INS_IDCODE); // RULE_01
    endfunction

    // Undriven mode and data pins are seen as logic one.
    always_comb begin
        pins.tms        = tms_in;
        pins.tdi        = tdi_in;
        pins.tms_driven = tms_drv;
        pins.tdi_driven = tdi_drv;
        tms = pins.tms_driven ? pins.tms : 1'b1; // RULE_13
        tdi = pins.tdi_driven ? pins.tdi : 1'b1; // RULE_13
    end

    // System reset is carried into the test clock domain by two stages.
    // The test clock may be parked low when the port is unused, so the
    // state may only settle once the clock runs; tms high does the same.
    always_ff @(posedge tck) begin
        rst_tck_q1 <= reset;
        rst_tck_q2 <= rst_tck_q1;
    end

    // Pad synchroniser on the test clock; only the second stage is read.
    // Capture thus sees the pins as they stood two test clocks earlier,
    // which costs nothing while the pins are held still around capture.
    always_ff @(posedge tck) begin
        pad_s1_q <= pad_in;
        pad_s2_q <= pad_s1_q;
    end

    // Next-state logic of the controller.
    // Five mode ones reach test-logic-reset from any state.
    always_comb begin
        st_d = st_q;
        unique case (st_q) // RULE_17
            sbst_pkg::ST_RESET:    st_d = tms ? sbst_pkg::ST_RESET
                                              : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_IDLE:     st_d = tms ? sbst_pkg::ST_SEL_DR
                                              : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_SEL_DR:   st_d = tms ? sbst_pkg::ST_SEL_IR
                                              : sbst_pkg::ST_CAP_DR;
            sbst_pkg::ST_CAP_DR:   st_d = tms ? sbst_pkg::ST_EXIT1_DR
                                              : sbst_pkg::ST_SHIFT_DR;
            sbst_pkg::ST_SHIFT_DR: st_d = tms ? sbst_pkg::ST_EXIT1_DR
                                              : sbst_pkg::ST_SHIFT_DR;
            sbst_pkg::ST_EXIT1_DR: st_d = tms ? sbst_pkg::ST_UPD_DR
                                              : sbst_pkg::ST_PAUSE_DR;
            sbst_pkg::ST_PAUSE_DR: st_d = tms ? sbst_pkg::ST_EXIT2_DR
                                              : sbst_pkg::ST_PAUSE_DR;
            sbst_pkg::ST_EXIT2_DR: st_d = tms ? sbst_pkg::ST_UPD_DR
                                              : sbst_pkg::ST_SHIFT_DR;
            sbst_pkg::ST_UPD_DR:   st_d = tms ? sbst_pkg::ST_SEL_DR
                                              : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_SEL_IR:   st_d = tms ? sbst_pkg::ST_RESET
                                              : sbst_pkg::ST_CAP_IR;
            sbst_pkg::ST_CAP_IR:   st_d = tms ? sbst_pkg::ST_EXIT1_IR
                                              : sbst_pkg::ST_SHIFT_IR;
            sbst_pkg::ST_SHIFT_IR: st_d = tms ? sbst_pkg::ST_EXIT1_IR
                                              : sbst_pkg::ST_SHIFT_IR;
            sbst_pkg::ST_EXIT1_IR: st_d = tms ? sbst_pkg::ST_UPD_IR
                                              : sbst_pkg::ST_PAUSE_IR;
            sbst_pkg::ST_PAUSE_IR: st_d = tms ? sbst_pkg::ST_EXIT2_IR
                                              : sbst_pkg::ST_PAUSE_IR;
            sbst_pkg::ST_EXIT2_IR: st_d = tms ? sbst_pkg::ST_UPD_IR
                                              : sbst_pkg::ST_SHIFT_IR;
            sbst_pkg::ST_UPD_IR:   st_d = tms ? sbst_pkg::ST_SEL_DR
                                              : sbst_pkg::ST_IDLE;
        endcase
    end

    // Scan register datapath: capture, shift and update per state.
    always_comb begin
        ir_sh_d = ir_sh_q;
        ir_d    = ir_q;
        byp_d   = byp_q;
        id_d    = id_q;
        bsr_d   = bsr_q;
        upd_d   = upd_q;
        unique case (st_q)
            sbst_pkg::ST_RESET: begin
                // Test-logic-reset restores the default instruction.
                ir_d = sbst_pkg::IR_RESET; // RULE_03
            end
            sbst_pkg::ST_CAP_IR: begin
                ir_sh_d = sbst_pkg::IR_CAPTURE;
            end
            sbst_pkg::ST_SHIFT_IR: begin
                // Shift toward the output; the last bit in is the msb.
                ir_sh_d = {tdi, ir_sh_q[2:1]}; // RULE_15
            end
            sbst_pkg::ST_UPD_IR: begin
                // A new EXTEST takes effect here, driving preloaded data.
                ir_d = ir_sh_q; // RULE_09
            end
            sbst_pkg::ST_CAP_DR: begin
                // The one-bit path starts each scan from a known zero.
                byp_d = 1'b0;
                if (is_id(ir_q)) begin
                    // The identification word is rebuilt on each capture.
                    id_d = ID_VALUE; // RULE_02
                end
                if (is_bsr(ir_q)) begin
                    // Pads are captured under all three boundary modes,
                    // including the one that floats the read data.
                    // The synchronised copy is taken, never the raw pins.
                    bsr_d = pad_s2_q; // RULE_05 RULE_08 RULE_12
                end
            end
            sbst_pkg::ST_SHIFT_DR: begin
                if (is_id(ir_q)) begin
                    id_d = {tdi, id_q[31:1]}; // RULE_02
                end else if (is_bsr(ir_q)) begin
                    bsr_d = {tdi, bsr_q[BSR_W-1:1]}; // RULE_06 RULE_11
                end else begin
                    // Bypass and the reserved codes use the one-bit path.
                    byp_d = tdi; // RULE_04
                end
            end
            sbst_pkg::ST_UPD_DR: begin
                if (is_bsr(ir_q)) begin
                    // Preload under sample or highz; drive under EXTEST.
                    upd_d = bsr_q; // RULE_08
                end
            end
            default: begin
                // No register action in the remaining states.
            end
        endcase
    end

    // Serial output selection, registered on the falling edge.
    always_comb begin
        tdo_d    = 1'b0;
        // The output is enabled only in the two shift states.
        tdo_oe_d = (st_q == sbst_pkg::ST_SHIFT_IR) ||
                   (st_q == sbst_pkg::ST_SHIFT_DR);
        if (st_q == sbst_pkg::ST_SHIFT_IR) begin
            tdo_d = ir_sh_q[0];
        end else if (st_q == sbst_pkg::ST_SHIFT_DR) begin
            if (is_id(ir_q)) begin
                tdo_d = id_q[0]; // RULE_02
            end else if (is_bsr(ir_q)) begin
                tdo_d = bsr_q[0]; // RULE_06 RULE_11
            end else begin
                tdo_d = byp_q; // RULE_04
            end
        end
    end

    // Mode bits held in the test clock domain. They follow the next
    // instruction, so they settle on the same edge as the instruction
    // itself; the test clock may stop right after update-IR.
    always_comb begin
        mode_tck_d.extest = (ir_d == sbst_pkg::INS_EXTEST); // RULE_08 RULE_09
        mode_tck_d.highz  = (ir_d == sbst_pkg::INS_HIGHZ);  // RULE_11
    end

    // Test clock registers; system reset acts through its synchroniser.
    always_ff @(posedge tck) begin
        if (rst_tck_q2) begin
            st_q       <= sbst_pkg::ST_RESET;
            ir_sh_q    <= sbst_pkg::IR_CAPTURE;
            ir_q       <= sbst_pkg::IR_RESET; // RULE_03
            byp_q      <= 1'b0;
            id_q       <= '0;
            bsr_q      <= '0;
            upd_q      <= '0;
            mode_tck_q <= '0;
        end else begin
            st_q       <= st_d;
            ir_sh_q    <= ir_sh_d;
            ir_q       <= ir_d;
            byp_q      <= byp_d;
            id_q       <= id_d;
            bsr_q      <= bsr_d;
            upd_q      <= upd_d;
            mode_tck_q <= mode_tck_d;
        end
    end

    // Serial output changes on the falling test clock edge.
    always_ff @(negedge tck) begin
        tdo_out <= tdo_d; // RULE_17
        tdo_oe  <= tdo_oe_d;
    end

    // The drive vector is a tck register straight to the pins; the pad
    // ring only uses it while the driver enable below is set.
    assign pad_drive = upd_q; // RULE_08

    // The two mode bits cross separately, so for one cycle the second
    // stage may hold a mix of old and new bits. Each output is blocked
    // while the other bit is set, so a mix falls to neither mode and
    // never to both; drivers and float are never on together.
    always_comb begin
        drv_en_d = mode_s2_q.extest && !mode_s2_q.highz; // RULE_09
        highz_d  = mode_s2_q.highz && !mode_s2_q.extest; // RULE_11
    end

    // Mode levels cross into mclk over two flip-flops; the pin ring acts
    // on them, so a short settle delay after update-IR is expected.
    // Reset parks both outputs off, which leaves the RAM in normal use.
    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_s1_q       <= '0;
            mode_s2_q       <= '0;
            extest_drv_en   <= 1'b0;
            read_data_highz <= 1'b0;
        end else begin
            mode_s1_q       <= mode_tck_q;
            mode_s2_q       <= mode_s1_q;
            extest_drv_en   <= drv_en_d;
            read_data_highz <= highz_d;
        end
    end

endmodule // sbst_tap

// ---- tb/sbst_tap_chk_sva.sv ----
// Checker for the boundary-scan port, bound onto its ports.
`timescale 1ns/1ps

module sbst_tap_chk #(
    parameter int BSR_W = sbst_pkg::BSR_LEN
) (
    // System side.
    input wire logic             mclk,
    input wire logic             reset,
    input wire logic             extest_drv_en,
    input wire logic             read_data_highz,
    // Test pins.
    input wire logic             tck,
    input wire logic             tms_in,
    input wire logic             tms_drv,
    input wire logic             tdi_in,
    input wire logic             tdi_drv,
    input wire logic             tdo_out,
    input wire logic             tdo_oe,
    // Pin ring.
    input wire logic [BSR_W-1:0] pad_in,
    input wire logic [BSR_W-1:0] pad_drive
);
    // Mode select as the port reads it: a floating pin counts as one.
    wire tms_e = tms_drv ? tms_in : 1'b1;

    // Mode pins are sampled on falling edges, so each sample is the value
    // that the preceding rising edge acted on.
    chk_reset_clears: assert property (@(posedge mclk)
        reset |=> !extest_drv_en && !read_data_highz)
        else $error("Pin modes not cleared by reset.");
    chk_modes_apart: assert property (@(posedge mclk)
        disable iff (reset) !(extest_drv_en && read_data_highz))
        else $error("Drive and float modes both on.");
    chk_extest_quiet: assert property (@(posedge mclk)
        disable iff (reset) $rose(extest_drv_en) |-> !tdo_oe)
        else $error("Drivers enabled during a shift.");
    chk_highz_quiet: assert property (@(posedge mclk)
        disable iff (reset) $rose(read_data_highz) |-> !tdo_oe)
        else $error("Read data floated during a shift.");
    chk_tlr_ones: assert property (@(negedge tck)
        disable iff (reset) tms_e [*5] |=> !tdo_oe)
        else $error("Five ones on mode did not leave shift.");
    chk_shift_exit: assert property (@(negedge tck)
        disable iff (reset) tdo_oe && tms_e |=> !tdo_oe)
        else $error("Shift not left on mode one.");
    chk_shift_hold: assert property (@(negedge tck)
        disable iff (reset) tdo_oe && !tms_e |=> tdo_oe)
        else $error("Shift left on mode zero.");
    // Shift is entered with mode low, either from capture (mode high two
    // clocks earlier, into select) or from exit2 (mode high just before).
    chk_shift_entry: assert property (@(negedge tck)
        disable iff (reset)
        $rose(tdo_oe) |-> !$past(tms_e) &&
        ($past(tms_e, 2) || $past(tms_e, 3)))
        else $error("Shift entered by an illegal path.");
    chk_drive_still: assert property (@(posedge tck)
        disable iff (reset) tdo_oe |=> $stable(pad_drive))
        else $error("Drive vector moved during a shift.");
endmodule // sbst_tap_chk

bind sbst_tap sbst_tap_chk #(.BSR_W(BSR_W)) u_chk (.mclk, .reset,
    .extest_drv_en, .read_data_highz, .tck, .tms_in, .tms_drv, .tdi_in,
    .tdi_drv, .tdo_out, .tdo_oe, .pad_in, .pad_drive);

// ---- tb/sbst_ctl_model.sv ----
// Model of the external test controller that drives the test pins.
`timescale 1ns/1ps

module sbst_ctl_model (
    // Test pins toward the port.
    output logic      tck,
    output logic      tms_in,
    output logic      tms_drv,
    output logic      tdi_in,
    output logic      tdi_drv,
    // Serial answer from the port.
    input  wire logic tdo_out,
    input  wire logic tdo_oe
);
    logic tms_float = 1'b0; // Leaves the mode pin undriven when set.
    logic tdi_float = 1'b0; // Leaves the data pin undriven when set.

    // The test clock stands low between frames, as for an unused port.
    initial begin
        tck     = 1'b0;
        tms_in  = 1'b1;
        tms_drv = 1'b1;
        tdi_in  = 1'b0;
        tdi_drv = 1'b1;
    end

    // One period: pins change while low, the answer is taken at the rise.
    // A floating pin toggles so that a stale level cannot pass for a one.
    task automatic tick(input logic m, input logic d, output logic q);
        tms_drv = !tms_float;
        tms_in  = tms_float ? !tms_in : m;
        tdi_drv = !tdi_float;
        tdi_in  = tdi_float ? !tdi_in : d;
        #7.5 tck = 1'b1;
        q = tdo_out;
        #7.5 tck = 1'b0;
    endtask

    // Mode held high for n periods, then one low period into idle.
    task automatic to_idle(input int n);
        logic q;
        repeat (n) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask

    // From idle, one instruction or data scan of n bits, back to idle.
    task automatic scan(input logic ir, input int n,
                        input logic [127:0] din, output logic [127:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, 1'b0, q);
        if (ir) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask
endmodule // sbst_ctl_model

// ---- tb/sbst_tap_tb_top.sv ----
// Self-checking bench for the boundary-scan test access port.
`timescale 1ns/1ps

module sbst_tap_tb_top;
    localparam int          W    = sbst_pkg::BSR_LEN;
    localparam logic [3:0]  REV  = 4'hA;     // Arbitrary value.
    localparam logic [15:0] PART = 16'h5A3C; // Arbitrary value.
    localparam logic [10:0] VEND = 11'h2B5;  // Arbitrary value.

    logic         mclk = 1'b0;      // System clock.
    logic         reset;            // Synchronous reset.
    logic [W-1:0] pad_in;           // Pad values offered for capture.
    logic [W-1:0] pad_drive;        // Drive vector seen at the pads.
    logic         extest_drv_en;    // Output drivers enabled.
    logic         read_data_highz;  // Read data floated.
    logic         tck, tms_in, tms_drv, tdi_in, tdi_drv, tdo_out, tdo_oe;
    int           err_count;        // Mismatches seen.
    int           samples_checked;  // Comparisons made.
    int           cycles;           // Clock cycles since start.
    int unsigned  seed_val;         // Value returned when seeding.
    logic [127:0] got, vec;         // Scan results and stimuli.
    logic [2:0]   codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};

    sbst_tap #(.ID_REV(REV), .ID_PART(PART), .ID_VEND(VEND)) dut (.mclk,
        .reset, .tck, .tms_in, .tms_drv, .tdi_in, .tdi_drv, .tdo_out,
        .tdo_oe, .pad_in, .pad_drive, .extest_drv_en, .read_data_highz);
    sbst_ctl_model ctl (.tck, .tms_in, .tms_drv, .tdi_in, .tdi_drv,
        .tdo_out, .tdo_oe);

    always #4 mclk = ~mclk;

    // A hang is cut short well beyond the roughly 1150 cycles needed.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            close_out();
        end
    end

    function automatic logic [127:0] rnd();
        return {$urandom(), $urandom(), $urandom(), $urandom()};
    endfunction
    // Identification word: revision, part, vendor and a fixed one.
    function automatic logic [127:0] id_exp();
        return {96'h0, REV, PART, VEND, 1'b1};
    endfunction
    // A one-bit path returns a captured zero, then the input delayed.
    function automatic logic [127:0] byp_exp(input logic [127:0] v,
                                             input int n);
        return {v[126:0], 1'b0} & ((128'h1 << n) - 128'h1);
    endfunction

    task automatic check(input logic [127:0] g, input logic [127:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Shifts an instruction in; the capture pattern comes back out.
    task automatic load_ir(input logic [2:0] c);
        ctl.scan(1'b1, 3, {125'h0, c}, got);
        check(got, 128'h1);
    endtask
    // Pin modes cross into mclk with a few cycles of latency.
    task automatic modes(input logic [1:0] e);
        repeat (6) @(posedge mclk);
        #1;
        check({126'h0, extest_drv_en, read_data_highz},
              {126'h0, e});
    endtask
    // New pad values, held still until the next capture is over.
    task automatic new_pads();
        logic [127:0] r;
        r = rnd();
        @(posedge mclk);
        #1 pad_in = r[W-1:0];
    endtask
    task automatic close_out();
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        pad_in = '0;
        seed_val = $urandom(32'hA8409DFC);
        fork
            begin
                repeat (8) @(posedge mclk);
                #1 reset = 1'b0;
            end
            ctl.to_idle(8);
        join
        ctl.scan(1'b0, 32, rnd(), got);
        check(got, id_exp());
        foreach (codes[i]) begin
            load_ir(codes[i]);
            vec = rnd();
            ctl.scan(1'b0, 16, vec, got);
            check(got, byp_exp(vec, 16));
        end
        load_ir(sbst_pkg::INS_HIGHZ);
        modes(2'b01);
        new_pads();
        ctl.scan(1'b0, W, rnd(), got);
        check(got, {21'h0, pad_in});
        load_ir(sbst_pkg::INS_SAMPLE);
        modes(2'b00);
        new_pads();
        vec = rnd() & {21'h0, {W{1'b1}}};
        ctl.scan(1'b0, W, vec, got);
        check(got, {21'h0, pad_in});
        check({21'h0, pad_drive}, vec);
        load_ir(sbst_pkg::INS_EXTEST);
        modes(2'b10);
        check({21'h0, pad_drive}, vec);
        new_pads();
        vec = rnd() & {21'h0, {W{1'b1}}};
        ctl.scan(1'b0, W, vec, got);
        check(got, {21'h0, pad_in});
        check({21'h0, pad_drive}, vec);
        // Undriven mode and data pins must read as ones.
        ctl.tms_float = 1'b1;
        ctl.tdi_float = 1'b1;
        ctl.to_idle(5);
        ctl.tms_float = 1'b0;
        ctl.to_idle(0);
        modes(2'b00);
        ctl.scan(1'b0, 32, '0, got);
        check(got, id_exp());
        load_ir(sbst_pkg::INS_BYPASS);
        ctl.scan(1'b0, 8, '0, got);
        check(got, byp_exp('1, 8));
        close_out();
    end
endmodule // sbst_tap_tb_top
